//--- src/ahci_capability_global_control.sv
/*
 * Capability and global control register bank of a single-port serial
 * ATA host controller, reached as an AHB-Lite slave.
 * Assumes a single AHB-Lite master, whole-word single transfers, and
 * port logic on the same clock.
 */
`timescale 1ns/1ps
module ahci_capability_global_control #(
  parameter bit          STAGGERED_SPINUP = 1'b0,  // Software spins up ports
  parameter int unsigned N_PORTS          = 1      // Event sources
) (
  input  wire logic                      clk_i,           // System clock, 40 MHz
  input  wire logic                      sys_rst_i,       // Synchronous reset, high
  input  wire logic                      ce_i,            // Clock enable, freezes state
  input  wire logic                      hsel_i,          // Slave select
  input  wire logic [31:0]               haddr_i,         // Byte address
  input  wire logic [1:0]                htrans_i,        // Transfer type
  input  wire logic                      hwrite_i,        // Write when high
  input  wire logic [2:0]                hsize_i,         // Transfer size, word only
  input  wire logic [31:0]               hwdata_i,        // Write data
  input  wire logic                      hready_i,        // Bus ready
  output logic      [31:0]               hrdata_o,        // Read data
  output logic                           hreadyout_o,     // Slave ready
  output logic                           hresp_o,         // Response, always OKAY
  input  wire logic [N_PORTS-1:0]        port_event_i,    // Pending port events
  input  wire logic                      engines_idle_i,  // Engines report idle
  input  wire logic                      comreset_done_i, // Link sent COMRESET
  output logic                           irq_o,           // Controller interrupt
  output logic                           engine_rst_o,    // Engines held idle
  output logic                           comreset_req_o   // COMRESET request
);
  import cap_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Fixed capability word

  // Every field is constant: nothing here is writable by software
  localparam logic [31:0] CAP_VALUE = {
    CAP_UPPER,          // 31..24
    ISS_VALUE,          // 23..20
    1'b0,               // 19
    1'b1,               // 18
    1'b1,               // 17
    1'b0,               // 16
    1'b1,               // 15
    1'b1,               // 14
    1'b1,               // 13
    NCS_VALUE,          // 12..8
    1'b1,               // 7
    1'b0,               // 6
    1'b0,               // 5
    NP_VALUE            // 4..0
  };

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic        ie;        // Global interrupt enable
    logic        hr;        // Controller reset in progress
    logic        start;     // Pulse to the sequencer
    logic        wr_pend;   // Write data phase pending
    logic        wr_ghc;    // Pending write targets control
    logic [31:0] rdata;     // Read data for the data phase
    logic        ready;     // Slave ready
    logic        resp;      // Slave response
  } bank_s;

  bank_s st, next_st;

  ctrl_link_if link ();     // Carrier to the helpers

  // Address phase decode
  logic            accept;  // Transfer taken this cycle
  logic [ADDR_W-1:0] addr;  // Decoded byte address

  assign accept = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;
  assign addr   = haddr_i[ADDR_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Next state
  //
  // The slave never stalls: an address phase is taken whenever the bus
  // is ready, and its data phase always completes in one cycle.
  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;
    next_st.ready = 1'b1;
    next_st.resp  = 1'b0;

    // Data phase of a write to the control register
    if (st.wr_pend && st.wr_ghc) begin
      if (hwdata_i[HR_BIT] && !st.hr) begin
        // Reset wins over any enable written alongside it
        next_st.hr    = 1'b1;
        next_st.start = 1'b1;
        next_st.ie    = 1'b0;
      end else if (!st.hr) begin
        // A zero in the reset bit neither starts nor aborts anything
        next_st.ie = hwdata_i[IE_BIT];
      end
      // While a reset runs the enable stays cleared
    end

    // Sequencer finished: reset bit clears itself
    if (link.done) begin
      next_st.hr = 1'b0;
    end

    // Address phase bookkeeping
    next_st.wr_pend = accept && hwrite_i;
    next_st.wr_ghc  = (addr == GHC_OFFSET);

    // Read data is formed from the next values, so a read that follows
    // a write back to back already sees the written enable
    next_st.rdata = 32'h0000_0000;
    if (accept && !hwrite_i) begin
      unique case (addr)
        CAP_OFFSET: begin
          next_st.rdata = CAP_VALUE;
        end
        GHC_OFFSET: begin
          next_st.rdata[AE_BIT] = 1'b1;
          next_st.rdata[IE_BIT] = next_st.ie;
          next_st.rdata[HR_BIT] = next_st.hr;
          // Bits 30..2 stay zero
        end
        default: begin
          next_st.rdata = 32'h0000_0000;       // Unmapped reads zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '{ie: IE_RESET, hr: HR_RESET, start: 1'b0, wr_pend: 1'b0,
              wr_ghc: 1'b0, rdata: 32'h0000_0000, ready: 1'b1, resp: 1'b0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  assign link.start = st.start;
  assign link.ie    = st.ie;

  // Global reset sequencer
  global_reset_seq #(
    .STAGGERED_SPINUP (STAGGERED_SPINUP)
  ) u_seq (
    .clk_i           (clk_i),
    .sys_rst_i       (sys_rst_i),
    .ce_i            (ce_i),
    .engines_idle_i  (engines_idle_i),
    .comreset_done_i (comreset_done_i),
    .link            (link)
  );

  // Interrupt gate
  irq_gate #(
    .N_PORTS (N_PORTS)
  ) u_gate (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .event_i   (port_event_i),
    .link      (link)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign hrdata_o       = st.rdata;
  assign hreadyout_o    = st.ready;
  assign hresp_o        = st.resp;
  assign irq_o          = link.irq;
  assign engine_rst_o   = link.engine_rst;
  // With staggered spin-up the link is left alone; software spins up
  assign comreset_req_o = link.comreset_req;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic cap_rd;   // Read of the capability word taken
  logic ghc_rd;   // Read of the control word taken
  logic ghc_wr1;  // Control write with reset bit set, idle
  logic ghc_wr0;  // Control write with reset bit clear

  assign cap_rd  = ce_i && accept && !hwrite_i && addr == CAP_OFFSET;
  assign ghc_rd  = ce_i && accept && !hwrite_i && addr == GHC_OFFSET;
  assign ghc_wr1 = ce_i && st.wr_pend && st.wr_ghc && hwdata_i[HR_BIT] && !st.hr;
  assign ghc_wr0 = ce_i && st.wr_pend && st.wr_ghc && !hwdata_i[HR_BIT];

  a_cap_speed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_rd |=> hrdata_o[23:20] == 4'h2)
    else $error("speed code wrong");
  a_cap_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_rd |=> hrdata_o[19:15] == 5'b01101)
    else $error("offset, mode or multiplier flags wrong");
  a_cap_power: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_rd |=> hrdata_o[14:13] == 2'b11)
    else $error("power state flags wrong");
  a_cap_slots: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_rd |=> hrdata_o[12:8] == 5'h1f && hrdata_o[7])
    else $error("slot count or coalescing wrong");
  a_cap_ports: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cap_rd |=> hrdata_o[6:0] == 7'h00)
    else $error("port count or absent features wrong");
  a_ghc_fixed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ghc_rd |=> hrdata_o[31] && hrdata_o[30:2] == 29'h0)
    else $error("control fixed bits wrong");
  a_hr_starts: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ghc_wr1 |=> st.hr && st.start ##1 engine_rst_o)
    else $error("reset not started");
  a_hr_ie_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ghc_wr1 |=> !st.ie)
    else $error("enable survived reset");
  a_hr_zero_ign: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ghc_wr0 && !st.start && !link.done) |=> st.hr == $past(st.hr))
    else $error("zero write changed reset bit");
  a_hr_self_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && link.done) |=> !st.hr)
    else $error("reset bit not cleared when done");
  a_ie_hold_rst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.hr && $past(st.hr)) |-> !st.ie)
    else $error("enable set during reset");
endmodule

//--- src/cap_ctrl_pkg.sv
/*
 * Shared constants for the capability and global control register bank:
 * register offsets, field positions, fixed capability values, timing.
 * Assumes a 40 MHz system clock and a 32-bit register bus.
 */
package cap_ctrl_pkg;

  // Bus and register map
  localparam int unsigned      ADDR_W        = 8;        // Byte address bits decoded
  localparam logic [7:0]       CAP_OFFSET    = 8'h00;    // Capability register
  localparam logic [7:0]       GHC_OFFSET    = 8'h04;    // Global control register
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;     // Bus transfer type

  // Capability fields
  localparam int unsigned      ISS_LSB       = 20;       // Speed code, bits 23..20
  localparam logic [3:0]       ISS_VALUE     = 4'h2;     // 1.5 and 3 Gbps
  localparam int unsigned      NONZERO_OFFSET_SUPPORT_BIT      = 19;       // Nonzero offset support
  localparam int unsigned      SAM_BIT       = 18;       // AHCI-only flag
  localparam int unsigned      SPM_BIT       = 17;       // Port multiplier support
  localparam int unsigned      RSVD_CAP_BIT  = 16;       // Reserved, reads zero
  localparam int unsigned      PMD_BIT       = 15;       // PIO multi block
  localparam int unsigned      SSC_BIT       = 14;       // Slumber capable
  localparam int unsigned      PSC_BIT       = 13;       // Partial capable
  localparam int unsigned      NCS_LSB       = 8;        // Slot count, bits 12..8
  localparam logic [4:0]       NCS_VALUE     = 5'h1f;    // 32 slots, minus one
  localparam int unsigned      COALESCING_SUPPORTED_BIT      = 7;        // Coalescing supported
  localparam int unsigned      EMS_BIT       = 6;        // Enclosure management
  localparam int unsigned      SXS_BIT       = 5;        // External connector
  localparam int unsigned      NP_LSB        = 0;        // Port count, bits 4..0
  localparam logic [4:0]       NP_VALUE      = 5'h00;    // One port, minus one
  localparam logic [7:0]       CAP_UPPER     = 8'he3;    // Bits 31..24, fixed

  // Global control fields
  localparam int unsigned      AE_BIT        = 31;       // AHCI enable, always one
  localparam int unsigned      IE_BIT        = 1;        // Global interrupt enable
  localparam int unsigned      HR_BIT        = 0;        // Controller reset request
  localparam logic             IE_RESET      = 1'b0;     // Enable after reset
  localparam logic             HR_RESET      = 1'b0;     // Reset request after reset

  // Global reset timing
  localparam int unsigned      CLK_MHZ       = 40;       // System clock rate
  localparam int unsigned      RST_HOLD_NS   = 100;      // Least engine reset hold
  localparam int unsigned      RST_HOLD_CYC  = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- src/ctrl_link_if.sv
/*
 * Carrier between the register bank and its two helpers: the global
 * reset sequencer and the interrupt gate. Single clock domain assumed.
 */
`timescale 1ns/1ps
interface ctrl_link_if;
  logic start;         // One-cycle pulse, begin global reset
  logic done;          // One-cycle pulse, global reset finished
  logic engine_rst;    // Level, holds transfer engines idle
  logic comreset_req;  // Level, asks link to send COMRESET
  logic ie;            // Global interrupt enable level
  logic irq;           // Gated interrupt, registered

  modport top  (output start, output ie, input done, input engine_rst,
                input comreset_req, input irq);
  modport seq  (input start, output done, output engine_rst, output comreset_req);
  modport gate (input ie, output irq);
endinterface

//--- src/global_reset_seq.sv
/*
 * Global reset sequencer: holds transfer engines in reset, then, unless
 * staggered spin-up is supported, asks the link for a COMRESET.
 * Assumes engines_idle_i and comreset_done_i come from the same clock.
 */
`timescale 1ns/1ps
module global_reset_seq
  import cap_ctrl_pkg::*;
#(
  parameter bit STAGGERED_SPINUP = 1'b0   // Software spins ports up itself
) (
  input  wire logic clk_i,            // System clock
  input  wire logic sys_rst_i,        // Synchronous reset, high
  input  wire logic ce_i,             // Clock enable
  input  wire logic engines_idle_i,   // Engines report idle
  input  wire logic comreset_done_i,  // Link finished COMRESET
  ctrl_link_if.seq  link              // Control carrier
);
  import cap_ctrl_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_HOLD = 2'b01, S_LINK = 2'b10, S_DONE = 2'b11
  } seq_e;

  typedef struct packed {
    seq_e       state;    // Sequencer state
    logic [7:0] cnt;      // Hold counter
    logic       rst;      // Engine reset level
    logic       comreset; // COMRESET request level
    logic       done;     // Completion pulse
  } seq_s;

  localparam logic [7:0] HOLD_LAST = 8'(RST_HOLD_CYC - 1);

  seq_s st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    unique case (st.state)
      S_IDLE: begin
        if (link.start) begin
          next_st.state = S_HOLD;
          next_st.rst   = 1'b1;
          next_st.cnt   = '0;
        end
      end
      S_HOLD: begin
        // Engines must see the full hold and report idle before release
        if (st.cnt != HOLD_LAST) begin
          next_st.cnt = st.cnt + 8'h01;
        end else if (engines_idle_i) begin
          next_st.rst = 1'b0;
          if (STAGGERED_SPINUP) begin
            next_st.state = S_DONE;
          end else begin
            next_st.state    = S_LINK;
            next_st.comreset = 1'b1;
          end
        end
      end
      S_LINK: begin
        if (comreset_done_i) begin
          next_st.comreset = 1'b0;
          next_st.state    = S_DONE;
        end
      end
      S_DONE: begin
        next_st.done  = 1'b1;
        next_st.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '{state: S_IDLE, cnt: 8'h00, rst: 1'b0, comreset: 1'b0, done: 1'b0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign link.done         = st.done;
  assign link.engine_rst   = st.rst;
  assign link.comreset_req = st.comreset;

  a_start_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && st.state == S_IDLE && link.start) |=> st.rst)
    else $error("engine reset not raised on start");
  a_comreset_req: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !STAGGERED_SPINUP && st.state == S_HOLD && st.cnt == HOLD_LAST &&
     engines_idle_i) |=> (st.comreset && !st.rst))
    else $error("COMRESET not requested after hold");
endmodule

//--- src/irq_gate.sv
/*
 * Interrupt gate: the global enable masks all pending port events
 * onto one registered interrupt line. Events come from the same clock.
 */
`timescale 1ns/1ps
module irq_gate #(
  parameter int unsigned N_PORTS = 1   // Ports feeding events
) (
  input  wire logic               clk_i,      // System clock
  input  wire logic               sys_rst_i,  // Synchronous reset, high
  input  wire logic               ce_i,       // Clock enable
  input  wire logic [N_PORTS-1:0] event_i,    // Pending port events
  ctrl_link_if.gate               link        // Control carrier
);
  typedef struct packed {
    logic irq;  // Registered interrupt
  } gate_s;

  gate_s st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // Mask with the global enable
  always_comb begin
    next_st     = st;
    next_st.irq = link.ie && (|event_i);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '{irq: 1'b0};
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign link.irq = st.irq;

  a_irq_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !link.ie) |=> !st.irq) else $error("interrupt passed while masked");
  a_irq_raised: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && link.ie && |event_i) |=> st.irq) else $error("enabled event not raised");
endmodule

//--- sim/ahci_capability_global_control_tb.sv
/*
 * Self-checking bench for the capability and global control bank.
 * Assumes the bank answers every bus transfer with no wait state and
 * that the capability word sits at byte 0, the control word at byte 4.
 */
`timescale 1ns/1ps
module ahci_capability_global_control_tb;
  localparam logic [31:0] CAPS_ADDR = 32'h0000_0000;  // Capability word
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0004;  // Global control word
  localparam logic [31:0] HOLE_ADDR = 32'h0000_0040;  // Unmapped offset
  // Lower 24 capability bits built field by field
  localparam logic [31:0] CAP_EXP = {8'h00, 4'h2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
                                     1'b1, 1'b1, 5'h1f, 1'b1, 1'b0, 1'b0, 5'h00};

  logic        clk_i;             // Bench clock
  logic        sys_rst_i;         // Synchronous reset
  logic        hsel, hwrite;      // Bus select and direction
  logic [31:0] haddr, hwdata;     // Bus address and write data
  logic [1:0]  htrans;            // Bus transfer type
  logic [2:0]  hsize;             // Bus transfer size
  logic [31:0] hrdata;            // Read data from the bank
  logic        hready, hresp;     // Bank ready and response
  logic        port_event;        // Pending port event
  logic        engines_idle;      // Engines report idle
  logic        comreset_done;     // Link finished COMRESET
  logic        irq, engine_rst, comreset_req;  // Bank side outputs
  int          err_total;         // Mismatches seen
  int          cmp_count;         // Comparisons made

  ahci_capability_global_control u_ahci_capability_global_control (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .port_event_i(port_event),
    .engines_idle_i(engines_idle), .comreset_done_i(comreset_done),
    .irq_o(irq), .engine_rst_o(engine_rst), .comreset_req_o(comreset_req));

  ////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Compare and count, report at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // One whole-word transfer; the bus never moves before hready is seen
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Capability fields, write protection and reserved places
  task automatic test_fields();
    logic [31:0] rd;
    bus(1'b0, CAPS_ADDR, 32'h0, rd);
    check(rd & 32'h00f0_0000, CAP_EXP & 32'h00f0_0000);
    check(rd & 32'h0008_0000, CAP_EXP & 32'h0008_0000);
    check(rd & 32'h0004_0000, CAP_EXP & 32'h0004_0000);
    check(rd & 32'h0002_0000, CAP_EXP & 32'h0002_0000);
    check(rd & 32'h0000_8000, CAP_EXP & 32'h0000_8000);
    check(rd & 32'h0000_6000, CAP_EXP & 32'h0000_6000);
    check(rd & 32'h0000_1f00, CAP_EXP & 32'h0000_1f00);
    check(rd & 32'h0000_0080, CAP_EXP & 32'h0000_0080);
    check(rd & 32'h0000_0060, CAP_EXP & 32'h0000_0060);
    check(rd & 32'h0000_001f, CAP_EXP & 32'h0000_001f);
    // Write all ones to the read-only word, then read it back
    bus(1'b1, CAPS_ADDR, 32'hffff_ffff, rd);
    bus(1'b0, CAPS_ADDR, 32'h0, rd);
    check(rd & 32'h00ff_ffff, CAP_EXP & 32'h00ff_ffff);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0000);
    // Reserved bits and the fixed enable survive a hostile write
    bus(1'b1, CTRL_ADDR, 32'h7fff_fffc, rd);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0000);
    bus(1'b0, HOLE_ADDR, 32'h0, rd);
    check(rd, 32'h0);
    $display("test_fields done");
  endtask

  // Global enable gates a pending event onto the interrupt
  task automatic test_irq();
    logic [31:0] rd;
    port_event <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, CTRL_ADDR, 32'h0000_0002, rd);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    port_event <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    port_event <= 1'b1;
    // A zero in the reset bit must not start anything
    bus(1'b1, CTRL_ADDR, 32'h0000_0002, rd);
    repeat (3) @(posedge clk_i);
    check({31'h0, engine_rst}, 32'h0);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0002);
    $display("test_irq done");
  endtask

  // Whole-controller reset with slow engines and a slow link
  task automatic test_reset();
    logic [31:0] rd;
    int          n;
    engines_idle <= 1'b0;
    bus(1'b1, CTRL_ADDR, 32'h0000_0003, rd);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0001);
    check({31'h0, engine_rst}, 32'h1);
    // Engines stay held while they are busy; a zero write is ignored
    bus(1'b1, CTRL_ADDR, 32'h0000_0002, rd);
    repeat (8) @(posedge clk_i);
    check({31'h0, engine_rst}, 32'h1);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0001);
    engines_idle <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (comreset_req !== 1'b1 && n < 20);
    check({31'h0, comreset_req}, 32'h1);
    repeat (3) @(posedge clk_i);
    bus(1'b0, CTRL_ADDR, 32'h0, rd);
    check(rd, 32'h8000_0001);
    comreset_done <= 1'b1;
    // Poll the reset bit for completion
    n = 0;
    do begin
      bus(1'b0, CTRL_ADDR, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    comreset_done <= 1'b0;
    check(rd, 32'h8000_0000);
    check({30'h0, engine_rst, comreset_req}, 32'h0);
    $display("test_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #(25 * 5000);
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    err_total     = 0;
    cmp_count     = 0;
    sys_rst_i     = 1'b1;
    hsel          = 1'b0;
    haddr         = 32'h0;
    htrans        = 2'h0;
    hwrite        = 1'b0;
    hsize         = 3'h2;
    hwdata        = 32'h0;
    port_event    = 1'b0;
    engines_idle  = 1'b1;
    comreset_done = 1'b0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    test_fields();
    test_irq();
    test_reset();
    test_done();
  end
endmodule
